//--- prmux_pkg.sv
package prmux_pkg;

	// register map, word addresses on the plain register port
	localparam logic [3:0] PIN_ASSIGN_REG0_ADDR = 4'h0;
	localparam logic [3:0] PIN_ASSIGN_REG1_ADDR = 4'h1;
	localparam logic [3:0] PIN_ASSIGN_REG2_ADDR = 4'h2;
	localparam logic [3:0] PIN_ASSIGN_REG3_ADDR = 4'h3;
	localparam logic [3:0] MISC_ROUTE_A_ADDR    = 4'h4;
	localparam logic [3:0] MISC_ROUTE_B_ADDR    = 4'h5;
	localparam logic [3:0] ROUTE_STATUS_ADDR    = 4'h6;

	// field layout
	localparam int PIN_SEL_W      = 6;
	localparam int MISC_SEL_W     = 5;
	localparam int PINS_PER_REG   = 5;
	localparam int MISC_PER_REG   = 6;
	localparam int PIN_INV18_BIT  = 30;
	localparam int PIN_INV19_BIT  = 31;
	localparam int MISC_INV4_BIT  = 30;
	localparam int MISC_INV5_BIT  = 31;
	localparam int PB18_IDX       = 17;
	localparam int PB19_IDX       = 18;

	// pin selection code bases
	localparam logic [5:0] PSEL_SERIAL_PORT_DATA = 6'h14;
	localparam logic [5:0] PSEL_SERIAL_PORT_CLK  = 6'h20;
	localparam logic [5:0] PSEL_SERIAL_PORT_FS   = 6'h26;
	localparam logic [5:0] PSEL_TIMER      = 6'h2C;
	localparam logic [5:0] PSEL_FLAG10     = 6'h2F;
	localparam logic [5:0] PSEL_MISCB      = 6'h30;
	localparam logic [5:0] PSEL_FLAG11     = 6'h34;
	localparam logic [5:0] PSEL_PCG_CLKA   = 6'h38;
	localparam logic [5:0] PSEL_PCG_CLKB   = 6'h39;
	localparam logic [5:0] PSEL_PCG_FSA    = 6'h3A;
	localparam logic [5:0] PSEL_PCG_FSB    = 6'h3B;
	localparam logic [5:0] PSEL_FLAG15     = 6'h3C;
	localparam logic [5:0] PSEL_LOW        = 6'h3E;
	localparam logic [5:0] PSEL_HIGH       = 6'h3F;

	// misc selection codes
	localparam logic [4:0] MSEL_TIMER    = 5'h14;
	localparam logic [4:0] MSEL_STROBE   = 5'h19;
	localparam logic [4:0] MSEL_PCG_CLKA = 5'h1A;
	localparam logic [4:0] MSEL_PCG_FSA  = 5'h1B;
	localparam logic [4:0] MSEL_PCG_CLKB = 5'h1C;
	localparam logic [4:0] MSEL_PCG_FSB  = 5'h1D;
	localparam logic [4:0] MSEL_LOW      = 5'h1E;
	localparam logic [4:0] MSEL_HIGH     = 5'h1F;

	// reset values: every selection forced to constant low
	localparam logic [31:0] PIN_ASSIGN_RESET = 32'h3EFB_EFBE;
	localparam logic [31:0] MISC_ROUTE_RESET = 32'h3DEF_7BDE;

	// peripheral sources that feed the crossbar
	typedef struct packed {
		logic [19:0] pb_out;      // pin buffer outputs 1..20
		logic [11:0] serial_port_data;  // 0A,0B,1A,1B .. 5B
		logic [5:0]  serial_port_clk;
		logic [5:0]  serial_port_fs;
		logic [2:0]  timer_out;
		logic [5:0]  gen_flag;    // flags 10..15
		logic [3:0]  misc_b_out;  // misc B 2..5
		logic        pcg_clka;
		logic        pcg_clkb;
		logic        pcg_fsa;
		logic        pcg_fsb;
		logic        strobe_out;  // parallel acquisition strobe
	} prmux_src_t;

	// register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} prmux_bus_t;

endpackage : prmux_pkg

//--- prmux_router.sv
// Operation
// - each pin input picks source by 6-bit code
// - codes 0x00-0x13 pick pin buffers 1-20
// - codes 0x14-0x1F pick serial data A/B
// - codes 0x20-0x25 pick serial port clocks
// - codes 0x26-0x2B pick serial frame syncs
// - codes 0x2C-0x2E pick timers 0-2
// - flag codes 0x2F, 0x34-0x37, 0x3C
// - codes 0x30-0x33 pick misc B 2-5
// - codes 0x38-0x3B pick precision clocks, syncs
// - 0x3D reserved, 0x3E low, 0x3F high
// - bits 30/31 invert pin 18/19 inputs
// - no invert on codes 18/19 in fields
// - misc inputs pick source by 5-bit code
// - misc codes 0x00-0x13 pick pin buffers
// - misc 0x14-0x16 timers, 0x17-0x18 reserved
// - misc 0x19 picks acquisition strobe
// - misc 0x1A-0x1D pick precision clocks, syncs
// - misc 0x1E low, 0x1F high
// - misc A bits 30/31 invert inputs 4/5
// - misc B 2-5 routable to pins
// - misc registers read back stored values
// - misc routing feeds interrupts, timers, pins
module prmux_router #(
	parameter int NUM_PINS = 20 // bonded pin buffers
) (
	input  wire logic                  clk_sys_i,   // processor clock
	input  wire logic                  rst_n_i,     // async reset, low
	input  wire prmux_pkg::prmux_bus_t bus_i,       // register request
	output logic [31:0]                rdata_o,     // read data, next cycle
	input  wire prmux_pkg::prmux_src_t src_i,       // unsynchronised sources
	output logic [NUM_PINS-1:0]        pin_in_o,    // pin buffer inputs
	output logic [5:0]                 misc_a_in_o, // misc A inputs 0..5
	output logic [5:0]                 misc_b_in_o  // misc B inputs 0..5
);

	typedef struct packed {
		logic [3:0][31:0]     pin_reg;
		logic [31:0]          misc_a_reg;
		logic [31:0]          misc_b_reg;
		prmux_pkg::prmux_src_t sync1;
		prmux_pkg::prmux_src_t sync2;
		logic [31:0]          rdata;
		logic [NUM_PINS-1:0]  pin_in;
		logic [5:0]           misc_a_in;
		logic [5:0]           misc_b_in;
	} prmux_state_t;

	prmux_state_t state_reg;
	prmux_state_t state_next;

	// pin crossbar: code to level, reserved codes fall to low
	function automatic logic pin_pick(input logic [5:0] code,
		input prmux_pkg::prmux_src_t s);
		logic v;
		v = 1'b0;
		if (code < prmux_pkg::PSEL_SERIAL_PORT_DATA) begin
			v = s.pb_out[code[4:0]];
		end else if (code < prmux_pkg::PSEL_SERIAL_PORT_CLK) begin
			v = s.serial_port_data[4'(code - prmux_pkg::PSEL_SERIAL_PORT_DATA)];
		end else if (code < prmux_pkg::PSEL_SERIAL_PORT_FS) begin
			v = s.serial_port_clk[3'(code - prmux_pkg::PSEL_SERIAL_PORT_CLK)];
		end else if (code < prmux_pkg::PSEL_TIMER) begin
			v = s.serial_port_fs[3'(code - prmux_pkg::PSEL_SERIAL_PORT_FS)];
		end else if (code < prmux_pkg::PSEL_FLAG10) begin
			v = s.timer_out[2'(code - prmux_pkg::PSEL_TIMER)];
		end else if (code == prmux_pkg::PSEL_FLAG10) begin
			v = s.gen_flag[0];
		end else if (code < prmux_pkg::PSEL_FLAG11) begin
			v = s.misc_b_out[2'(code - prmux_pkg::PSEL_MISCB)];
		end else if (code < prmux_pkg::PSEL_PCG_CLKA) begin
			v = s.gen_flag[3'(code - prmux_pkg::PSEL_FLAG11) + 3'd1];
		end else if (code == prmux_pkg::PSEL_PCG_CLKA) begin
			v = s.pcg_clka;
		end else if (code == prmux_pkg::PSEL_PCG_CLKB) begin
			v = s.pcg_clkb;
		end else if (code == prmux_pkg::PSEL_PCG_FSA) begin
			v = s.pcg_fsa;
		end else if (code == prmux_pkg::PSEL_PCG_FSB) begin
			v = s.pcg_fsb;
		end else if (code == prmux_pkg::PSEL_FLAG15) begin
			v = s.gen_flag[5];
		end else if (code == prmux_pkg::PSEL_HIGH) begin
			v = 1'b1;
		end
		return v; // 0x3D and 0x3E stay low
	endfunction : pin_pick

	// misc crossbar: code to level, reserved codes fall to low
	function automatic logic misc_pick(input logic [4:0] code,
		input prmux_pkg::prmux_src_t s);
		logic v;
		v = 1'b0;
		if (code < prmux_pkg::MSEL_TIMER) begin
			v = s.pb_out[code];
		end else if (code < 5'h17) begin
			v = s.timer_out[2'(code - prmux_pkg::MSEL_TIMER)];
		end else if (code == prmux_pkg::MSEL_STROBE) begin
			v = s.strobe_out;
		end else if (code == prmux_pkg::MSEL_PCG_CLKA) begin
			v = s.pcg_clka;
		end else if (code == prmux_pkg::MSEL_PCG_FSA) begin
			v = s.pcg_fsa;
		end else if (code == prmux_pkg::MSEL_PCG_CLKB) begin
			v = s.pcg_clkb;
		end else if (code == prmux_pkg::MSEL_PCG_FSB) begin
			v = s.pcg_fsb;
		end else if (code == prmux_pkg::MSEL_HIGH) begin
			v = 1'b1;
		end
		return v; // 0x17, 0x18, 0x1E low
	endfunction : misc_pick

	// registers, read port, crossbars; all outputs registered
	always_comb begin
		logic [5:0] pcode;
		logic [4:0] mcode;
		logic       inv;
		int         ri;
		int         fi;
		pcode = 6'h00;
		mcode = 5'h00;
		inv = 1'b0;
		ri = 0;
		fi = 0;
		state_next = state_reg;
		// two flops on every source: they come from other clocks and pins
		state_next.sync1 = src_i;
		state_next.sync2 = state_reg.sync1;
		// register writes land this edge; routing follows on the next
		if (bus_i.wr) begin
			if (bus_i.addr <= prmux_pkg::PIN_ASSIGN_REG3_ADDR) begin
				state_next.pin_reg[bus_i.addr[1:0]] = bus_i.wdata;
			end else if (bus_i.addr == prmux_pkg::MISC_ROUTE_A_ADDR) begin
				state_next.misc_a_reg = bus_i.wdata;
			end else if (bus_i.addr == prmux_pkg::MISC_ROUTE_B_ADDR) begin
				state_next.misc_b_reg = bus_i.wdata;
			end
		end
		// read data valid only the cycle after the strobe
		state_next.rdata = 32'h0000_0000;
		if (bus_i.rd) begin
			if (bus_i.addr <= prmux_pkg::PIN_ASSIGN_REG3_ADDR) begin
				state_next.rdata = state_reg.pin_reg[bus_i.addr[1:0]];
			end else if (bus_i.addr == prmux_pkg::MISC_ROUTE_A_ADDR) begin
				state_next.rdata = state_reg.misc_a_reg;
			end else if (bus_i.addr == prmux_pkg::MISC_ROUTE_B_ADDR) begin
				state_next.rdata = state_reg.misc_b_reg;
			end else if (bus_i.addr == prmux_pkg::ROUTE_STATUS_ADDR) begin
				state_next.rdata = {state_reg.misc_b_in, state_reg.misc_a_in,
					state_reg.pin_in};
			end
		end
		// pin crossbar, five 6-bit fields per register
		for (int p = 0; p < NUM_PINS; p++) begin
			ri = p / prmux_pkg::PINS_PER_REG;
			fi = (p % prmux_pkg::PINS_PER_REG) * prmux_pkg::PIN_SEL_W;
			pcode = state_reg.pin_reg[ri][fi +: prmux_pkg::PIN_SEL_W];
			inv = 1'b0;
			// inversion is vetoed by the upper field, not the pin's own field
			if (p == prmux_pkg::PB18_IDX) begin
				inv = state_reg.pin_reg[3][prmux_pkg::PIN_INV18_BIT]
					&& (state_reg.pin_reg[3][23:18] != 6'd18);
			end else if (p == prmux_pkg::PB19_IDX) begin
				inv = state_reg.pin_reg[3][prmux_pkg::PIN_INV19_BIT]
					&& (state_reg.pin_reg[3][29:24] != 6'd19);
			end
			state_next.pin_in[p] = pin_pick(pcode, state_reg.sync2) ^ inv;
		end
		// misc crossbars, six 5-bit fields per register
		for (int m = 0; m < prmux_pkg::MISC_PER_REG; m++) begin
			mcode = state_reg.misc_a_reg[m*prmux_pkg::MISC_SEL_W +: prmux_pkg::MISC_SEL_W];
			inv = 1'b0;
			if (m == 4) begin
				inv = state_reg.misc_a_reg[prmux_pkg::MISC_INV4_BIT];
			end else if (m == 5) begin
				inv = state_reg.misc_a_reg[prmux_pkg::MISC_INV5_BIT];
			end
			state_next.misc_a_in[m] = misc_pick(mcode, state_reg.sync2) ^ inv;
			mcode = state_reg.misc_b_reg[m*prmux_pkg::MISC_SEL_W +: prmux_pkg::MISC_SEL_W];
			state_next.misc_b_in[m] = misc_pick(mcode, state_reg.sync2);
		end
	end

	// single state register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg.pin_reg    <= {4{prmux_pkg::PIN_ASSIGN_RESET}};
			state_reg.misc_a_reg <= prmux_pkg::MISC_ROUTE_RESET;
			state_reg.misc_b_reg <= prmux_pkg::MISC_ROUTE_RESET;
			state_reg.sync1      <= '0;
			state_reg.sync2      <= '0;
			state_reg.rdata      <= 32'h0000_0000;
			state_reg.pin_in     <= '0;
			state_reg.misc_a_in  <= 6'h00;
			state_reg.misc_b_in  <= 6'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata_o     = state_reg.rdata;
	assign pin_in_o    = state_reg.pin_in;
	assign misc_a_in_o = state_reg.misc_a_in;
	assign misc_b_in_o = state_reg.misc_b_in;

	// checks: register effect and crossbar corners
	AST_WRITE_NEXT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.wr && bus_i.addr == prmux_pkg::MISC_ROUTE_A_ADDR
		|=> state_reg.misc_a_reg == $past(bus_i.wdata))
		else $error("misc route A write not stored");
	AST_READBACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.rd && bus_i.addr == prmux_pkg::MISC_ROUTE_B_ADDR && !bus_i.wr
		|=> rdata_o == $past(state_reg.misc_b_reg))
		else $error("misc route B readback wrong");
	AST_PIN_HIGH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == prmux_pkg::PSEL_HIGH |=> pin_in_o[0])
		else $error("pin 1 not high for high code");
	AST_PIN_RSVD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h3D |=> !pin_in_o[0])
		else $error("reserved pin code not low");
	AST_PIN_LOOP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[1][5:0] == 6'h00 |=> pin_in_o[5] == $past(state_reg.sync2.pb_out[0]))
		else $error("pin 6 does not follow pin buffer 1");
	AST_TIMER_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h2E |=> pin_in_o[0] == $past(state_reg.sync2.timer_out[2]))
		else $error("timer 2 code misrouted");
	AST_INV18: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[3][30] && state_reg.pin_reg[3][17:12] == prmux_pkg::PSEL_LOW
		&& state_reg.pin_reg[3][23:18] != 6'd18
		|=> pin_in_o[17])
		else $error("pin 18 inversion missing");
	AST_NOINV18: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[3][30] && state_reg.pin_reg[3][23:18] == 6'd18
		&& state_reg.pin_reg[3][17:12] == prmux_pkg::PSEL_HIGH
		|=> pin_in_o[17])
		else $error("pin 18 inverted despite veto code");
	AST_INV19: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[3][31] && state_reg.pin_reg[3][23:18] == prmux_pkg::PSEL_LOW
		&& state_reg.pin_reg[3][29:24] != 6'd19
		|=> pin_in_o[18])
		else $error("pin 19 inversion missing");
	AST_MISC_INV4: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_a_reg[30] && state_reg.misc_a_reg[24:20] == prmux_pkg::MSEL_LOW
		|=> misc_a_in_o[4])
		else $error("misc A4 inversion missing");
	AST_MISC_RSVD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == 5'h17 |=> !misc_b_in_o[0])
		else $error("reserved misc code not low");
	AST_MISC_STROBE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == prmux_pkg::MSEL_STROBE
		|=> misc_b_in_o[0] == $past(state_reg.sync2.strobe_out))
		else $error("strobe misrouted");

	// register port: stores, readback, idle read data
	AST_RDATA_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!bus_i.rd |=> rdata_o == 32'h0000_0000)
		else $error("read data not zero when idle");
	AST_READ_A: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.rd && bus_i.addr == prmux_pkg::MISC_ROUTE_A_ADDR
		|=> rdata_o == $past(state_reg.misc_a_reg))
		else $error("misc route A readback wrong");
	AST_READ_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.rd && bus_i.addr == prmux_pkg::PIN_ASSIGN_REG3_ADDR
		|=> rdata_o == $past(state_reg.pin_reg[3]))
		else $error("pin reg 3 readback wrong");
	AST_PIN_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.wr && bus_i.addr <= prmux_pkg::PIN_ASSIGN_REG3_ADDR
		|=> state_reg.pin_reg[$past(bus_i.addr[1:0])] == $past(bus_i.wdata))
		else $error("pin reg write not stored");

	// pin crossbar corners: low, serial data, clock and sync, timer, flag, misc B and precision codes
	AST_PIN_LOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == prmux_pkg::PSEL_LOW |=> !pin_in_o[0])
		else $error("pin 1 not low for low code");
	AST_SERIAL_PORT_DA0: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h14
		|=> pin_in_o[0] == $past(state_reg.sync2.serial_port_data[0]))
		else $error("serial 0A data misrouted");
	AST_SERIAL_PORT_DB5: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h1F
		|=> pin_in_o[0] == $past(state_reg.sync2.serial_port_data[11]))
		else $error("serial 5B data misrouted");
	AST_SERIAL_PORT_CLK5: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h25
		|=> pin_in_o[0] == $past(state_reg.sync2.serial_port_clk[5]))
		else $error("serial clock 5 misrouted");
	AST_SERIAL_PORT_FS0: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h26
		|=> pin_in_o[0] == $past(state_reg.sync2.serial_port_fs[0]))
		else $error("serial sync 0 misrouted");
	AST_TIMER0_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h2C
		|=> pin_in_o[0] == $past(state_reg.sync2.timer_out[0]))
		else $error("timer 0 code misrouted");
	AST_FLAG10: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h2F
		|=> pin_in_o[0] == $past(state_reg.sync2.gen_flag[0]))
		else $error("flag 10 misrouted");
	AST_FLAG12: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h35
		|=> pin_in_o[0] == $past(state_reg.sync2.gen_flag[2]))
		else $error("flag 12 misrouted");
	AST_FLAG15: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h3C
		|=> pin_in_o[0] == $past(state_reg.sync2.gen_flag[5]))
		else $error("flag 15 misrouted");
	AST_MISCB_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h30
		|=> pin_in_o[0] == $past(state_reg.sync2.misc_b_out[0]))
		else $error("misc B 2 misrouted to pin");
	AST_PCG_CLKA_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h38
		|=> pin_in_o[0] == $past(state_reg.sync2.pcg_clka))
		else $error("precision clock A misrouted");
	AST_PCG_FSB_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[0][5:0] == 6'h3B
		|=> pin_in_o[0] == $past(state_reg.sync2.pcg_fsb))
		else $error("precision sync B misrouted");

	// misc crossbar corners; bank B never inverts
	AST_MISC_PB20: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == 5'h13
		|=> misc_b_in_o[0] == $past(state_reg.sync2.pb_out[19]))
		else $error("pin buffer 20 misrouted");
	AST_MISC_TIMER2: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == 5'h16
		|=> misc_b_in_o[0] == $past(state_reg.sync2.timer_out[2]))
		else $error("misc timer 2 misrouted");
	AST_MISC_RSVD18: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == 5'h18 |=> !misc_b_in_o[0])
		else $error("reserved misc code 18 not low");
	AST_MISC_PCG_FSA: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == prmux_pkg::MSEL_PCG_FSA
		|=> misc_b_in_o[0] == $past(state_reg.sync2.pcg_fsa))
		else $error("misc precision sync A misrouted");
	AST_MISC_HIGH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[4:0] == prmux_pkg::MSEL_HIGH |=> misc_b_in_o[0])
		else $error("misc high code not high");
	AST_MISC_A_LOW: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_a_reg[4:0] == prmux_pkg::MSEL_LOW |=> !misc_a_in_o[0])
		else $error("misc A0 low code not low");
	AST_MISC_A_STROBE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_a_reg[4:0] == prmux_pkg::MSEL_STROBE
		|=> misc_a_in_o[0] == $past(state_reg.sync2.strobe_out))
		else $error("misc A strobe misrouted");
	AST_MISCB_NOINV: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_b_reg[24:20] == prmux_pkg::MSEL_LOW |=> !misc_b_in_o[4])
		else $error("misc B4 inverted");

	COV_PIN_WRITE: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.wr && bus_i.addr == prmux_pkg::PIN_ASSIGN_REG3_ADDR);
	COV_INV19: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[3][31] && pin_in_o[18]);
	COV_MISC_READ: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.rd && bus_i.addr == prmux_pkg::MISC_ROUTE_A_ADDR);
	// the veto case and the misc inversion are the easy ones to miss
	COV_INV_VETO: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.pin_reg[3][30] && state_reg.pin_reg[3][23:18] == 6'd18);
	COV_MISC_INV5: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		state_reg.misc_a_reg[31] && state_reg.misc_a_reg[29:25] == prmux_pkg::MSEL_HIGH);

endmodule : prmux_router

//--- prmux_router_bench.sv
module prmux_router_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys_i;
	logic                  rst_n_i;
	prmux_pkg::prmux_bus_t bus;
	prmux_pkg::prmux_src_t src;
	logic [31:0]           rdata;
	logic [19:0]           pins;
	logic [5:0]            misc_a;
	logic [5:0]            misc_b;
	logic [6:0]            pick;
	logic                  level;
	logic [31:0]           val;
	int                    failures;
	int                    n_compared;

	prmux_src_model model (.pick_i(pick), .level_i(level), .src_o(src));
	prmux_router uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
		.src_i(src), .pin_in_o(pins), .misc_a_in_o(misc_a), .misc_b_in_o(misc_b));

	// 125 MHz
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	// bus cycles: one strobe cycle, then a gap edge so strobes never double up
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk_sys_i);
		#1 chk(rdata, 32'h0000_0000, "read data not dropped");
	endtask : rd

	// set one source, wait out two sync flops plus the output flop
	task automatic drive(input int idx, input logic lv);
		@(posedge clk_sys_i);
		pick <= (idx < 0) ? 7'h7F : 7'(idx);
		level <= lv;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask : drive

	// flat source index per pin code; -1 constant low, -2 constant high
	function automatic int pin_src(input logic [5:0] c);
		if (c < 6'h14) return 42 + int'(c);
		if (c < 6'h20) return 30 + int'(c) - 20;
		if (c < 6'h26) return 24 + int'(c) - 32;
		if (c < 6'h2C) return 18 + int'(c) - 38;
		if (c < 6'h2F) return 15 + int'(c) - 44;
		if (c == 6'h2F) return 9;
		if (c < 6'h34) return 5 + int'(c) - 48;
		if (c < 6'h38) return 10 + int'(c) - 52;
		if (c < 6'h3C) return 4 - (int'(c) - 56);
		if (c == 6'h3C) return 14;
		return (c == 6'h3F) ? -2 : -1;
	endfunction : pin_src

	function automatic int misc_src(input logic [4:0] m);
		if (m < 5'h14) return 42 + int'(m);
		if (m < 5'h17) return 15 + int'(m) - 20;
		case (m)
			5'h19: return 0;
			5'h1A: return 4;
			5'h1B: return 2;
			5'h1C: return 3;
			5'h1D: return 1;
			5'h1F: return -2;
			default: return -1;
		endcase
	endfunction : misc_src

	function automatic logic expv(input int idx, input logic lv);
		return (idx == -2) ? 1'b1 : ((idx == -1) ? 1'b0 : lv);
	endfunction : expv

	// hang guard: no wait below is open-ended, this only catches a stuck run
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		failures++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		rst_n_i = 1'b0;
		bus = '0;
		pick = 7'h7F;
		level = 1'b0;
		failures = 0;
		n_compared = 0;
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(prmux_pkg::PIN_ASSIGN_REG3_ADDR, val);
		chk(val, prmux_pkg::PIN_ASSIGN_RESET, "pin reg reset");
		rd(prmux_pkg::MISC_ROUTE_A_ADDR, val);
		chk(val, prmux_pkg::MISC_ROUTE_RESET, "misc reg reset");
		$display("test reset values done");
		// every pin code, source driven both ways
		for (int c = 0; c < 64; c++) begin
			wr(prmux_pkg::PIN_ASSIGN_REG0_ADDR, {prmux_pkg::PIN_ASSIGN_RESET[31:6], 6'(c)});
			for (int lv = 0; lv < 2; lv++) begin
				drive(pin_src(6'(c)), lv[0]);
				chk(32'(pins[0]), 32'(expv(pin_src(6'(c)), lv[0])), "pin route");
			end
		end
		$display("test pin codes done");
		// every misc code, both banks at once
		for (int m = 0; m < 32; m++) begin
			wr(prmux_pkg::MISC_ROUTE_A_ADDR, {prmux_pkg::MISC_ROUTE_RESET[31:5], 5'(m)});
			wr(prmux_pkg::MISC_ROUTE_B_ADDR, {prmux_pkg::MISC_ROUTE_RESET[31:5], 5'(m)});
			for (int lv = 0; lv < 2; lv++) begin
				drive(misc_src(5'(m)), lv[0]);
				chk(32'(misc_a[0]), 32'(expv(misc_src(5'(m)), lv[0])), "misc a route");
				chk(32'(misc_b[0]), 32'(expv(misc_src(5'(m)), lv[0])), "misc b route");
			end
		end
		$display("test misc codes done");
		// a new selection lands one edge after the write edge, not on it
		wr(prmux_pkg::PIN_ASSIGN_REG0_ADDR, prmux_pkg::PIN_ASSIGN_RESET);
		drive(-1, 1'b0);
		wr(prmux_pkg::PIN_ASSIGN_REG0_ADDR, {prmux_pkg::PIN_ASSIGN_RESET[31:6], 6'h3F});
		#1 chk(32'(pins[0]), 32'h0000_0000, "switch too early");
		@(posedge clk_sys_i);
		#1 chk(32'(pins[0]), 32'h0000_0001, "switch too late");
		$display("test latency done");
		// both pin inverts on constant high, then the self-select exception
		wr(prmux_pkg::PIN_ASSIGN_REG3_ADDR, {2'b11, 6'h3E, 6'h3F, 6'h3F, 6'h3E, 6'h3E});
		drive(-1, 1'b0);
		chk(32'(pins[18:17]), 32'h0000_0000, "pin invert");
		wr(prmux_pkg::PIN_ASSIGN_REG3_ADDR, {2'b11, 6'h3E, 6'h12, 6'h3F, 6'h3E, 6'h3E});
		drive(-1, 1'b0);
		chk(32'(pins[18:17]), 32'h0000_0001, "invert exception");
		wr(prmux_pkg::MISC_ROUTE_A_ADDR, {2'b11, 5'h1F, 5'h1F, 5'h1E, 5'h1E, 5'h1E, 5'h1E});
		drive(-1, 1'b0);
		chk(32'(misc_a[5:4]), 32'h0000_0000, "misc invert");
		$display("test inversion done");
		// readback, and an unmapped place that must neither store nor answer
		wr(prmux_pkg::MISC_ROUTE_A_ADDR, 32'hC123_4567);
		wr(prmux_pkg::MISC_ROUTE_B_ADDR, 32'h3ABC_DEF1);
		wr(4'hF, 32'hFFFF_FFFF);
		rd(prmux_pkg::MISC_ROUTE_A_ADDR, val);
		chk(val, 32'hC123_4567, "misc a readback");
		rd(prmux_pkg::MISC_ROUTE_B_ADDR, val);
		chk(val, 32'h3ABC_DEF1, "misc b readback");
		rd(4'hF, val);
		chk(val, 32'h0000_0000, "unmapped read");
		$display("test register access done");
		tally_and_finish();
	end
endmodule : prmux_router_bench

//--- prmux_src_model.sv
// stand-in for the audio peripherals feeding the crossbar
module prmux_src_model (
	input  wire logic [6:0]       pick_i,  // flat source index, 7f for none
	input  wire logic             level_i, // level of the picked source
	output prmux_pkg::prmux_src_t src_o    // peripheral outputs
);
	logic [61:0] flat;

	// all other sources sit at the opposite level, so a wrong pick shows
	always_comb begin
		flat = {62{~level_i}};
		if (pick_i < 7'h3E) begin
			flat[pick_i[5:0]] = level_i;
		end
		src_o = prmux_pkg::prmux_src_t'(flat);
	end
endmodule : prmux_src_model
